// ==== include/ccsel_pkg.sv ====
// Package for the clock ratio and sub-clock select block: map, fields, resets, timing
package ccsel_pkg;

    // ----------------------------------------
    // Register map (word index on the plain register port)
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_RATIO_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_SUB_CTRL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h2;

    // ----------------------------------------
    // clock_ratio_control fields
    // ----------------------------------------
    localparam int SYS_RATIO_LSB = 8;
    localparam int PERIPH_RATIO_LSB = 4;
    localparam int BUS_RATIO_LSB = 0;
    localparam int RATIO_W = 3;
    localparam logic [15:0] RATIO_CTRL_RESET = 16'h0222;

    // Ratio codes: 000 x8, 001 x4, 010 x2, 011 x1, 1xx prohibited
    localparam logic [2:0] RATIO_X8 = 3'h0;
    localparam logic [2:0] RATIO_X4 = 3'h1;
    localparam logic [2:0] RATIO_X2 = 3'h2;
    localparam logic [2:0] RATIO_X1 = 3'h3;
    localparam int RATIO_BAD_BIT = 2;

    // ----------------------------------------
    // sub_clock_control fields
    // ----------------------------------------
    localparam int OSC_HALT_BIT = 3;
    localparam int PLL_HALT_BIT = 2;
    localparam int WAKE_SRC_BIT = 1;
    localparam int SLOW_SRC_BIT = 0;
    localparam logic [7:0] SUB_CTRL_RESET = 8'h0c;

    // ----------------------------------------
    // Status register fields
    // ----------------------------------------
    localparam int ST_SYS_LSB = 8;
    localparam int ST_PERIPH_LSB = 4;
    localparam int ST_BUS_LSB = 0;
    localparam int ST_SUB_BIT = 12;
    localparam int ST_STANDBY_BIT = 13;
    localparam int ST_PENDING_BIT = 14;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int SUB_DIVIDE = 128;
    localparam int MAIN_PHASES = 8;
    localparam int PHASE_W = 3;

    typedef struct packed {
        logic [2:0] sys;
        logic [2:0] periph;
        logic [2:0] bus;
    } ccsel_ratios_t;

    typedef struct packed {
        logic sys;
        logic periph;
        logic bus;
    } ccsel_ticks_t;

endpackage

// ==== src/ccsel_top.sv ====
// Clock ratio selection, sub-clock selection and standby clock control
//
// What this block does
// - Peripheral ratio 000..011 gives input clock x8, x4, x2, x1; 1xx prohibited.
// - Peripheral clock faster than system clock runs at system clock instead.
// - Bus ratio 000..011 gives input clock x8, x4, x2, x1; 1xx prohibited.
// - Bus clock faster than system clock runs at system clock instead.
// - Oscillator halt bit, reset 1, stops oscillator in standby when set.
// - PLL halt bit, reset 1, stops PLL during sub-clock operation when set.
// - Wake source bit picks main or sub clock after interrupt ends standby.
// - Wake source bit matters only when standby was entered from sub-clock operation.
// - Slow source bit set puts all three clocks on the sub clock.
// - Slow source bit clears on write of 0 or standby entry from sub-clock operation with wake bit 0.
// - Sub clock is the shaped external clock divided by 128.
// - New settings apply after the bus cycle ends, within one input clock; a switch to the sub clock waits for a sub tick.
// - System clock setting wins; peripheral and bus never exceed it, except when their own new code is prohibited and a faster old ratio stays.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module ccsel_top
    import ccsel_pkg::*;
#(
    parameter int SUB_DIV = SUB_DIVIDE
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic bus_busy,
    input wire logic standby_enter,
    input wire logic standby_wake,
    input wire logic ext_clk_pin,
    output logic sys_clk_en,
    output logic periph_clk_en,
    output logic bus_clk_en,
    output logic osc_halt,
    output logic pll_halt,
    output logic standby_active,
    output logic sub_active
);

    localparam int SUB_W = $clog2(SUB_DIV);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    generate
        if (SUB_DIV < 2 || (1 << SUB_W) != SUB_DIV) begin : g_bad_div
            $error("SUB_DIV must be a power of two of at least 2");
        end
    endgenerate

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [15:0] ratio_ctrl_r;
    logic [7:0] sub_ctrl_r;
    logic pending_r;
    logic in_standby_r;
    logic from_sub_r;
    ccsel_ratios_t applied_r;
    logic sub_src_r;

    logic wr_ratio;
    logic wr_sub;
    logic auto_clear;
    assign wr_ratio = reg_wr && (reg_addr == ADDR_RATIO_CTRL);
    assign wr_sub = reg_wr && (reg_addr == ADDR_SUB_CTRL);
    // Standby entry from sub-clock operation with wake bit clear drops the slow source
    assign auto_clear = standby_enter && !in_standby_r && sub_src_r && !sub_ctrl_r[WAKE_SRC_BIT];

    // All bits are stored as written; reserved bits are software's to keep at zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ratio_ctrl_r <= RATIO_CTRL_RESET;
        end else if (wr_ratio) begin
            ratio_ctrl_r <= reg_wdata;
        end
    end

    // Auto-clear wins over a write in the same cycle; both cannot come from one CPU anyway
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_ctrl_r <= SUB_CTRL_RESET;
        end else begin
            if (wr_sub) begin
                sub_ctrl_r <= reg_wdata[7:0];
            end
            if (auto_clear) begin
                sub_ctrl_r[SLOW_SRC_BIT] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Standby tracking
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            in_standby_r <= 1'b0;
            from_sub_r <= 1'b0;
        end else if (standby_enter && !in_standby_r) begin
            in_standby_r <= 1'b1;
            from_sub_r <= sub_src_r;
        end else if (standby_wake && in_standby_r) begin
            in_standby_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // External clock shaping and sub-clock divider
    // ----------------------------------------
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic shaped_r;
    logic [SUB_W-1:0] sub_cnt_r;
    logic shaped_rise;
    logic sub_tick;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_clk_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // A level counts only when two stages agree, which rejects single-sample noise
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shaped_r <= 1'b0;
        end else if (ext_s2_r == ext_s3_r) begin
            shaped_r <= ext_s3_r;
        end
    end

    assign shaped_rise = (ext_s2_r == ext_s3_r) && ext_s3_r && !shaped_r;
    assign sub_tick = shaped_rise && (sub_cnt_r == SUB_W'(SUB_DIV - 1));

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_cnt_r <= '0;
        end else if (shaped_rise) begin
            sub_cnt_r <= sub_cnt_r + 1'b1;
        end
    end

    // ----------------------------------------
    // Main clock phase counter
    // ----------------------------------------
    // One full input-clock period is eight system cycles; every ratio ends a period
    // on the last phase, so switching there never cuts a pulse short.
    logic [PHASE_W-1:0] phase_r;
    logic phase_end;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= '0;
        end else begin
            phase_r <= phase_r + 1'b1;
        end
    end

    assign phase_end = (phase_r == PHASE_W'(MAIN_PHASES - 1));

    function automatic logic ratio_tick(input logic [2:0] code, input logic [PHASE_W-1:0] ph);
        logic t;
        t = 1'b0;
        unique case (code)
            RATIO_X8: t = 1'b1;
            RATIO_X4: t = ph[0];
            RATIO_X2: t = &ph[1:0];
            RATIO_X1: t = &ph;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // Larger code means slower clock; the slower of own and system ratio wins
    function automatic logic [2:0] clamp_ratio(input logic [2:0] own, input logic [2:0] sys);
        return (own > sys) ? own : sys;
    endfunction

    // ----------------------------------------
    // Deferred application of new settings
    // ----------------------------------------
    ccsel_ratios_t req_ratios;
    logic req_sub;
    logic boundary;
    logic apply;

    always_comb begin
        req_ratios.sys = ratio_ctrl_r[SYS_RATIO_LSB +: RATIO_W];
        req_ratios.periph = clamp_ratio(ratio_ctrl_r[PERIPH_RATIO_LSB +: RATIO_W], req_ratios.sys);
        req_ratios.bus = clamp_ratio(ratio_ctrl_r[BUS_RATIO_LSB +: RATIO_W], req_ratios.sys);
    end

    // After waking from standby entered in sub mode, the wake bit decides the source
    assign req_sub = sub_ctrl_r[SLOW_SRC_BIT];

    // Going to the sub clock waits for a sub tick so the first slow period is whole
    assign boundary = (req_sub && !sub_src_r) ? sub_tick : phase_end;
    assign apply = pending_r && !bus_busy && boundary;

    // A write in the applying cycle keeps the request pending
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pending_r <= 1'b0;
        end else if (wr_ratio || wr_sub || auto_clear || (standby_wake && in_standby_r)) begin
            pending_r <= 1'b1;
        end else if (apply) begin
            pending_r <= 1'b0;
        end
    end

    // Prohibited codes leave the previously applied ratio in force
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            applied_r <= '{sys: RATIO_X2, periph: RATIO_X2, bus: RATIO_X2};
        end else if (apply) begin
            if (!req_ratios.sys[RATIO_BAD_BIT]) begin
                applied_r.sys <= req_ratios.sys;
            end
            if (!req_ratios.periph[RATIO_BAD_BIT]) begin
                applied_r.periph <= req_ratios.periph;
            end
            if (!req_ratios.bus[RATIO_BAD_BIT]) begin
                applied_r.bus <= req_ratios.bus;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_src_r <= 1'b0;
        end else if (apply) begin
            sub_src_r <= req_sub;
        end
    end

    // ----------------------------------------
    // Clock enables
    // ----------------------------------------
    ccsel_ticks_t tick_nxt;

    always_comb begin
        if (in_standby_r) begin
            tick_nxt = '0;
        end else if (sub_src_r) begin
            tick_nxt = '{sys: sub_tick, periph: sub_tick, bus: sub_tick};
        end else begin
            tick_nxt.sys = ratio_tick(applied_r.sys, phase_r);
            tick_nxt.periph = ratio_tick(applied_r.periph, phase_r);
            tick_nxt.bus = ratio_tick(applied_r.bus, phase_r);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sys_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            bus_clk_en <= 1'b0;
        end else begin
            sys_clk_en <= tick_nxt.sys;
            periph_clk_en <= tick_nxt.periph;
            bus_clk_en <= tick_nxt.bus;
        end
    end

    // ----------------------------------------
    // Oscillator, PLL and mode outputs
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_halt <= 1'b0;
            pll_halt <= 1'b0;
            standby_active <= 1'b0;
            sub_active <= 1'b0;
        end else begin
            osc_halt <= in_standby_r && sub_ctrl_r[OSC_HALT_BIT];
            pll_halt <= sub_src_r && sub_ctrl_r[PLL_HALT_BIT];
            standby_active <= in_standby_r;
            sub_active <= sub_src_r;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    logic [DATA_W-1:0] rd_nxt;

    always_comb begin
        rd_nxt = '0;
        unique case (reg_addr)
            ADDR_RATIO_CTRL: rd_nxt = ratio_ctrl_r;
            ADDR_SUB_CTRL: rd_nxt = {8'h00, sub_ctrl_r};
            ADDR_STATUS: begin
                rd_nxt[ST_SYS_LSB +: RATIO_W] = applied_r.sys;
                rd_nxt[ST_PERIPH_LSB +: RATIO_W] = applied_r.periph;
                rd_nxt[ST_BUS_LSB +: RATIO_W] = applied_r.bus;
                rd_nxt[ST_SUB_BIT] = sub_src_r;
                rd_nxt[ST_STANDBY_BIT] = in_standby_r;
                rd_nxt[ST_PENDING_BIT] = pending_r;
            end
            default: rd_nxt = '0;
        endcase
    end

    // Read data stands for exactly the cycle after the strobe
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rd_nxt;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

`default_nettype wire

// ==== bench/ccsel_top_chk.sv ====
// Port checker for the clock ratio and sub-clock select block
`timescale 1ns/1ns
`default_nettype none
module ccsel_top_chk
    import ccsel_pkg::*;
#(
    parameter int SUB_DIV = SUB_DIVIDE
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic bus_busy,
    input wire logic standby_enter,
    input wire logic standby_wake,
    input wire logic ext_clk_pin,
    input wire logic sys_clk_en,
    input wire logic periph_clk_en,
    input wire logic bus_clk_en,
    input wire logic osc_halt,
    input wire logic pll_halt,
    input wire logic standby_active,
    input wire logic sub_active
);
    logic [4:0] quiet_r;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // Gap since the last system pulse in main mode
    // ----------------------------------------
    // Slowest main ratio pulses every 8 cycles; slack covers a pending apply
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            quiet_r <= 5'h0;
        end else if (sys_clk_en || sub_active || standby_active) begin
            quiet_r <= 5'h0;
        end else begin
            quiet_r <= quiet_r + 5'h1;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_PERIPH_NOT_FASTER: assert property (periph_clk_en |-> sys_clk_en)
        else $error("peripheral pulse without system pulse");
    AST_BUS_NOT_FASTER: assert property (bus_clk_en |-> sys_clk_en)
        else $error("bus pulse without system pulse");
    AST_OSC_HALT_ONLY_STANDBY: assert property (osc_halt |-> standby_active)
        else $error("oscillator halted outside standby");
    AST_PLL_HALT_ONLY_SUB: assert property (pll_halt |-> sub_active)
        else $error("pll halted outside sub-clock operation");
    AST_SUB_SAME_PULSES: assert property (sub_active && $past(sub_active) && $past(sub_active, 2)
        |-> periph_clk_en == sys_clk_en && bus_clk_en == sys_clk_en)
        else $error("clocks differ in sub-clock operation");
    AST_MAIN_KEEPS_TICKING: assert property (quiet_r <= 5'h10)
        else $error("system clock stalled in main mode");
    AST_STANDBY_QUIET: assert property (standby_active && $past(standby_active)
        |-> !sys_clk_en && !periph_clk_en && !bus_clk_en)
        else $error("clock pulse during standby");
    AST_STANDBY_ENTRY: assert property (standby_enter && !standby_active && !standby_wake
        |-> ##2 standby_active)
        else $error("standby not entered");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data outside read answer cycle");
endmodule
`default_nettype wire

// ==== bench/ccsel_top_tb.sv ====
// Self-checking bench for the clock ratio and sub-clock select block
`timescale 1ns/1ns
`default_nettype none
module ccsel_top_tb;
    import ccsel_pkg::*;
    localparam int SUB_DIV = 4;
    logic sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, bus_busy = 1'b0;
    logic standby_enter = 1'b0, standby_wake = 1'b0, ext_clk_pin = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 16'h0, reg_rdata, rd_val, n_sys, n_per, n_bus;
    logic sys_clk_en, periph_clk_en, bus_clk_en, osc_halt, pll_halt, standby_active, sub_active;
    logic [2:0] s_app = 3'h2, p_app = 3'h2, b_app = 3'h2;
    logic [31:0] rnd;
    int failures = 0, checks = 0, seed = 32'h5910, ext_cnt = 0;

    always #10 sys_clk = ~sys_clk;

    // External pin toggles every 5 cycles: one sub tick per 40 cycles
    always @(posedge sys_clk) begin
        ext_cnt <= (ext_cnt == 4) ? 0 : ext_cnt + 1;
        ext_clk_pin <= (ext_cnt == 4) ? ~ext_clk_pin : ext_clk_pin;
    end

    ccsel_top #(.SUB_DIV(SUB_DIV)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_busy(bus_busy),
        .standby_enter(standby_enter), .standby_wake(standby_wake), .ext_clk_pin(ext_clk_pin),
        .sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en), .bus_clk_en(bus_clk_en),
        .osc_halt(osc_halt), .pll_halt(pll_halt), .standby_active(standby_active), .sub_active(sub_active)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic final_report;
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask

    task automatic count(input int n);
        n_sys = 16'h0;
        n_per = 16'h0;
        n_bus = 16'h0;
        repeat (n) begin
            @(posedge sys_clk);
            n_sys = n_sys + {15'h0, sys_clk_en};
            n_per = n_per + {15'h0, periph_clk_en};
            n_bus = n_bus + {15'h0, bus_clk_en};
        end
    endtask

    task automatic expect_main;
        logic [2:0] pe, be;
        pe = (p_app > s_app) ? p_app : s_app;
        be = (b_app > s_app) ? b_app : s_app;
        repeat (12) @(posedge sys_clk);
        count(64);
        check(n_sys, 16'h40 >> s_app);
        check(n_per, 16'h40 >> pe);
        check(n_bus, 16'h40 >> be);
    endtask

    task automatic expect_sub;
        repeat (40) @(posedge sys_clk);
        count(160);
        check(n_sys, 16'h4);
        check(n_per, 16'h4);
        check(n_bus, 16'h4);
    endtask

    task automatic ratio_test(input logic [2:0] s, input logic [2:0] p, input logic [2:0] b);
        wr(ADDR_RATIO_CTRL, {5'h0, s, 1'b0, p, 1'b0, b});
        rd(ADDR_RATIO_CTRL, rd_val);
        check(rd_val, {5'h0, s, 1'b0, p, 1'b0, b});
        s_app = s[2] ? s_app : s;
        p_app = p[2] ? p_app : p;
        b_app = b[2] ? b_app : b;
        expect_main;
    endtask

    task automatic wait_sub(input logic want);
        int k;
        k = 0;
        while (sub_active !== want && k < 400) begin
            @(posedge sys_clk);
            k++;
        end
        check({15'h0, sub_active}, {15'h0, want});
    endtask

    task automatic stby(input logic wake);
        standby_wake <= wake;
        standby_enter <= ~wake;
        @(posedge sys_clk);
        standby_wake <= 1'b0;
        standby_enter <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rd(ADDR_RATIO_CTRL, rd_val);
        check(rd_val, RATIO_CTRL_RESET);
        rd(ADDR_SUB_CTRL, rd_val);
        check(rd_val, {8'h0, SUB_CTRL_RESET});
        rd(4'hf, rd_val);
        check(rd_val, 16'h0);
        expect_main;
        ratio_test(3'h0, 3'h1, 3'h2);
        ratio_test(3'h4, 3'h5, 3'h7);
        ratio_test(3'h3, 3'h0, 3'h0);
        for (int i = 0; i < 12; i++) begin
            rnd = $random(seed);
            ratio_test({1'b0, rnd[1:0]}, {1'b0, rnd[5:4]}, {1'b0, rnd[9:8]});
        end
        ratio_test(3'h3, 3'h3, 3'h3);
        // New setting waits for the bus cycle to finish
        bus_busy <= 1'b1;
        wr(ADDR_RATIO_CTRL, 16'h0000);
        repeat (20) @(posedge sys_clk);
        rd(ADDR_STATUS, rd_val);
        check({12'h0, rd_val[ST_PENDING_BIT], rd_val[ST_SYS_LSB +: 3]}, 16'h000b);
        bus_busy <= 1'b0;
        {s_app, p_app, b_app} = 9'h0;
        expect_main;
        // Sub clock, then standby with wake on main clock
        wr(ADDR_SUB_CTRL, 16'h000d);
        wait_sub(1'b1);
        check({14'h0, pll_halt, osc_halt}, 16'h0002);
        expect_sub;
        stby(1'b0);
        check({14'h0, osc_halt, standby_active}, 16'h0003);
        rd(ADDR_SUB_CTRL, rd_val);
        check(rd_val, 16'h000c);
        count(64);
        check(n_sys | n_per | n_bus, 16'h0);
        stby(1'b1);
        wait_sub(1'b0);
        expect_main;
        // Wake on sub clock, halts off
        wr(ADDR_SUB_CTRL, 16'h0003);
        wait_sub(1'b1);
        check({15'h0, pll_halt}, 16'h0);
        stby(1'b0);
        check({14'h0, osc_halt, standby_active}, 16'h0001);
        rd(ADDR_SUB_CTRL, rd_val);
        check(rd_val, 16'h0003);
        stby(1'b1);
        check({15'h0, sub_active}, 16'h0001);
        expect_sub;
        // Writing 0 leaves sub mode; wake bit ignored from main clock
        wr(ADDR_SUB_CTRL, 16'h0002);
        wait_sub(1'b0);
        stby(1'b0);
        stby(1'b1);
        check({15'h0, sub_active}, 16'h0);
        expect_main;
        final_report;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        final_report;
    end
endmodule

bind ccsel_top ccsel_top_chk #(.SUB_DIV(SUB_DIV)) chk_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_busy(bus_busy),
    .standby_enter(standby_enter), .standby_wake(standby_wake), .ext_clk_pin(ext_clk_pin),
    .sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en), .bus_clk_en(bus_clk_en),
    .osc_halt(osc_halt), .pll_halt(pll_halt), .standby_active(standby_active), .sub_active(sub_active)
);
`default_nettype wire
